// File: design/pmac_pkg.sv
// Package for the power monitor alert and conversion control block
package pmac_pkg;
  // Register byte offsets
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] ALCFG_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] SHUNT_OFF = 8'h14;
  localparam logic [7:0] BUS_OFF = 8'h18;
  localparam logic [7:0] CURR_OFF = 8'h1C;
  localparam logic [7:0] POW_OFF = 8'h20;
  localparam logic [7:0] CAL_OFF = 8'h24;
  localparam logic [7:0] ADDR_OFF = 8'h28;
  // Config field positions
  localparam int MODE_LSB = 0;
  localparam int SHUNT_AVG_LSB = 3;
  localparam int BUS_AVG_LSB = 7;
  localparam int GAIN_LSB = 11;
  localparam int BRNG_BIT = 13;
  localparam int TRIG_BIT = 14;
  // Alert config bits
  localparam int LATCH_BIT = 0;
  localparam int ALEN_BIT = 1;
  // Status bits
  localparam int VOLT_RDY_BIT = 6;
  localparam int TEMP_RDY_BIT = 5;
  localparam int ALF_BIT = 0;
  // Reset values
  localparam logic [15:0] CFG_RST = 16'h2387;
  localparam logic [1:0] ALCFG_RST = 2'h0;
  localparam logic [6:0] ADDR_RST = 7'h5C;
  // Modes
  localparam logic [2:0] MODE_PDOWN = 3'h0;
  localparam logic [2:0] MODE_CONT_BOTH = 3'h7;
  // Alert response address
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int RECOVER_US = 40;
  localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
  localparam int SAMPLE_CYC = 16;
  typedef enum logic [2:0] {
    CS_IDLE, CS_RECOVER, CS_SHUNT, CS_BUS, CS_MULT, CS_DONE
  } pmac_conv_t;
  typedef enum logic [2:0] {
    AS_IDLE, AS_ADDR, AS_ACK, AS_SEND, AS_NACK, AS_WAIT
  } pmac_ara_t;
endpackage : pmac_pkg

// File: design/pmac_core.sv
// Conversion sequencer, result registers and alert logic with alert response
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmac_core #(
  parameter int RECOVER_CYCLES = pmac_pkg::RECOVER_CYC,
  parameter int SAMPLE_CYCLES = pmac_pkg::SAMPLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [15:0] i_shunt_sample,
  input wire logic [15:0] i_bus_sample,
  input wire logic i_fault,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic o_sda_out,
  output logic o_alert_oe,
  output logic o_alert_out,
  output logic o_conv_busy
);
  import pmac_pkg::*;

  logic [15:0] cfg_ff;
  logic [1:0] alcfg_ff;
  logic [15:0] cal_ff;
  logic [6:0] addr_ff;
  logic [15:0] shunt_ff, bus_ff, curr_ff;
  logic [31:0] pow_ff;
  logic volt_rdy_ff, temp_rdy_ff, alf_ff;
  logic [31:0] acc_ff;
  logic [7:0] scnt_ff;
  logic [15:0] wcnt_ff;
  logic trig_ff;
  pmac_conv_t cs_ff;
  logic [2:0] mode;
  logic wr, rd, stat_rd, sample_tick, ara_ok;
  logic [7:0] n_shunt, n_bus;

  assign mode = cfg_ff[MODE_LSB +: 3];
  assign wr = i_psel && i_penable && i_pwrite;
  // Read clears at the edge that latches read data
  assign rd = i_psel && !i_penable && !i_pwrite;
  assign stat_rd = rd && (i_paddr == STAT_OFF);

  function automatic logic [7:0] avg_count(input logic [3:0] f);
    avg_count = f[3] ? 8'(1 << f[2:0]) : 8'h01;
  endfunction : avg_count
  assign n_shunt = avg_count(cfg_ff[SHUNT_AVG_LSB +: 4]);
  assign n_bus = avg_count(cfg_ff[BUS_AVG_LSB +: 4]);

  // APB slave, zero wait states
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_ff <= CFG_RST;
      alcfg_ff <= ALCFG_RST;
      cal_ff <= 16'h0000;
      addr_ff <= ADDR_RST;
    end else if (wr) begin
      if (i_paddr == CFG_OFF) begin
        cfg_ff <= i_pwdata[15:0];
      end else if (i_paddr == ALCFG_OFF) begin
        alcfg_ff <= i_pwdata[1:0];
      end else if (i_paddr == CAL_OFF) begin
        cal_ff <= i_pwdata[15:0];
      end else if (i_paddr == ADDR_OFF) begin
        addr_ff <= i_pwdata[6:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        o_prdata <= 32'h0000_0000;
        if (i_paddr == CFG_OFF) begin
          o_prdata <= {16'h0000, cfg_ff};
        end else if (i_paddr == STAT_OFF) begin
          o_prdata <= {25'h0, volt_rdy_ff, temp_rdy_ff, 4'h0, alf_ff};
        end else if (i_paddr == ALCFG_OFF) begin
          o_prdata <= {30'h0, alcfg_ff};
        end else if (i_paddr == SHUNT_OFF) begin
          o_prdata <= {16'h0000, shunt_ff};
        end else if (i_paddr == BUS_OFF) begin
          o_prdata <= {16'h0000, bus_ff};
        end else if (i_paddr == CURR_OFF) begin
          o_prdata <= {16'h0000, curr_ff};
        end else if (i_paddr == POW_OFF) begin
          o_prdata <= pow_ff;
        end else if (i_paddr == CAL_OFF) begin
          o_prdata <= {16'h0000, cal_ff};
        end else if (i_paddr == ADDR_OFF) begin
          o_prdata <= {25'h0, addr_ff};
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // Trigger request from config write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      trig_ff <= 1'b0;
    end else if (wr && i_paddr == CFG_OFF) begin
      trig_ff <= i_pwdata[TRIG_BIT];
    end else if (cs_ff == CS_IDLE || cs_ff == CS_RECOVER) begin
      trig_ff <= trig_ff && !(cs_ff == CS_IDLE && wcnt_ff == 16'h0000);
    end
  end

  assign sample_tick = (scnt_ff == 8'(SAMPLE_CYCLES - 1));

  // Conversion sequencer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_ff <= CS_RECOVER;
      wcnt_ff <= 16'h0000;
      scnt_ff <= 8'h00;
      acc_ff <= 32'h0;
      shunt_ff <= 16'h0000;
      bus_ff <= 16'h0000;
      curr_ff <= 16'h0000;
      pow_ff <= 32'h0;
      o_conv_busy <= 1'b0;
    end else begin
      case (cs_ff)
        CS_IDLE: begin
          o_conv_busy <= 1'b0;
          if (mode == MODE_PDOWN) begin
            wcnt_ff <= 16'h0000;
          end else if (mode[2] || trig_ff) begin
            cs_ff <= CS_RECOVER;
          end
        end
        CS_RECOVER: begin
          if (mode == MODE_PDOWN) begin
            wcnt_ff <= 16'h0000;
          end else if (wcnt_ff == 16'(RECOVER_CYCLES)) begin
            cs_ff <= mode[0] ? CS_SHUNT : CS_BUS;
            o_conv_busy <= 1'b1;
            acc_ff <= 32'h0;
            scnt_ff <= 8'h00;
            wcnt_ff <= 16'h0000;
          end else begin
            wcnt_ff <= wcnt_ff + 16'h0001;
          end
        end
        CS_SHUNT: begin
          scnt_ff <= sample_tick ? 8'h00 : scnt_ff + 8'h01;
          if (sample_tick) begin
            acc_ff <= acc_ff + {{16{i_shunt_sample[15]}}, i_shunt_sample};
            wcnt_ff <= wcnt_ff + 16'h0001;
            if (wcnt_ff[7:0] == n_shunt - 8'h01) begin
              shunt_ff <= 16'($signed(acc_ff + {{16{i_shunt_sample[15]}}, i_shunt_sample})
                >>> $clog2(32'(n_shunt)));
              acc_ff <= 32'h0;
              wcnt_ff <= 16'h0000;
              cs_ff <= mode[1] ? CS_BUS : CS_MULT;
            end
          end
        end
        CS_BUS: begin
          scnt_ff <= sample_tick ? 8'h00 : scnt_ff + 8'h01;
          if (sample_tick) begin
            acc_ff <= acc_ff + {16'h0000, i_bus_sample};
            wcnt_ff <= wcnt_ff + 16'h0001;
            if (wcnt_ff[7:0] == n_bus - 8'h01) begin
              bus_ff <= 16'((acc_ff + {16'h0000, i_bus_sample}) >> $clog2(32'(n_bus)));
              acc_ff <= 32'h0;
              wcnt_ff <= 16'h0000;
              cs_ff <= CS_MULT;
            end
          end
        end
        CS_MULT: begin
          curr_ff <= 16'((32'(signed'(shunt_ff)) * 32'(cal_ff)) >>> 12);
          cs_ff <= CS_DONE;
        end
        CS_DONE: begin
          pow_ff <= 32'((32'(curr_ff) * 32'(bus_ff)) >> 12);
          o_conv_busy <= 1'b0;
          cs_ff <= mode[2] ? (mode[0] ? CS_SHUNT : CS_BUS) : CS_IDLE;
        end
        default: cs_ff <= CS_IDLE;
      endcase
    end
  end

  // Ready flags: set wins over read clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      volt_rdy_ff <= 1'b0;
      temp_rdy_ff <= 1'b0;
    end else if (cs_ff == CS_DONE) begin
      volt_rdy_ff <= 1'b1;
      temp_rdy_ff <= 1'b1;
    end else if (stat_rd) begin
      volt_rdy_ff <= 1'b0;
      temp_rdy_ff <= 1'b0;
    end
  end

  // Gain and bus range decode full-scale values; no logic uses them
  logic [8:0] shunt_fs_mv;
  assign shunt_fs_mv = 9'(40) << cfg_ff[GAIN_LSB +: 2];
  logic [5:0] bus_fs_v;
  assign bus_fs_v = cfg_ff[BRNG_BIT] ? 6'd32 : 6'd16;

  // Pin synchronisers
  logic [1:0] scl_s_ff, sda_s_ff, fault_s_ff;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_s_ff <= 2'b11;
      sda_s_ff <= 2'b11;
      fault_s_ff <= 2'b00;
    end else begin
      scl_s_ff <= {scl_s_ff[0], i_scl};
      sda_s_ff <= {sda_s_ff[0], i_sda};
      fault_s_ff <= {fault_s_ff[0], i_fault};
    end
  end
  logic scl_d_ff, sda_d_ff;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s_ff[1];
      sda_d_ff <= sda_s_ff[1];
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_ff[1] && !scl_d_ff;
  assign scl_fall = !scl_s_ff[1] && scl_d_ff;
  assign start_c = scl_s_ff[1] && scl_d_ff && sda_d_ff && !sda_s_ff[1];
  assign stop_c = scl_s_ff[1] && scl_d_ff && !sda_d_ff && sda_s_ff[1];

  // Alert flag: fault sets, status read, disable or response success clears
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      alf_ff <= 1'b0;
    end else if (!alcfg_ff[ALEN_BIT]) begin
      alf_ff <= 1'b0;
    end else if (fault_s_ff[1]) begin
      alf_ff <= 1'b1;
    end else if (!alcfg_ff[LATCH_BIT]) begin
      alf_ff <= 1'b0;
    end else if (stat_rd || ara_ok) begin
      alf_ff <= 1'b0;
    end
  end

  // Open-drain alert, low only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_alert_oe <= 1'b0;
      o_alert_out <= 1'b0;
    end else begin
      o_alert_oe <= alf_ff;
      o_alert_out <= 1'b0;
    end
  end

  // Alert response slave
  pmac_ara_t as_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic lost_ff;
  logic [7:0] tx_byte;
  assign tx_byte = {addr_ff, 1'b1};
  assign ara_ok = (as_ff == AS_NACK) && scl_rise && !lost_ff;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      as_ff <= AS_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      lost_ff <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else if (start_c) begin
      as_ff <= AS_ADDR;
      bit_ff <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_c) begin
      as_ff <= AS_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (as_ff)
        AS_ADDR: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_s_ff[1]};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            if (sh_ff == {ARA_ADDR, 1'b1} && alf_ff
                && alcfg_ff[ALEN_BIT] && alcfg_ff[LATCH_BIT]) begin
              o_sda_oe <= 1'b1;
              as_ff <= AS_ACK;
            end else begin
              as_ff <= AS_WAIT;
            end
          end
        end
        AS_ACK: begin
          if (scl_fall) begin
            bit_ff <= 4'h0;
            lost_ff <= 1'b0;
            o_sda_oe <= !tx_byte[7];
            as_ff <= AS_SEND;
          end
        end
        AS_SEND: begin
          if (scl_rise && o_sda_oe == 1'b0 && !sda_s_ff[1]) begin
            lost_ff <= 1'b1;
            as_ff <= AS_WAIT;
          end else if (scl_rise) begin
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_ff == 4'h8) begin
              o_sda_oe <= 1'b0;
              as_ff <= AS_NACK;
            end else begin
              o_sda_oe <= !tx_byte[3'(7 - bit_ff)];
            end
          end
        end
        AS_NACK: begin
          if (scl_rise) begin
            as_ff <= AS_WAIT;
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  a_alert_follows_flag: assert property (@(posedge i_clk) disable iff (i_reset)
    alf_ff |=> o_alert_oe) else $error("alert not driven");
  a_alert_never_high: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_alert_out) else $error("alert driven high");
  a_loser_no_ack: assert property (@(posedge i_clk) disable iff (i_reset)
    lost_ff && as_ff == AS_WAIT |-> !o_sda_oe) else $error("loser drives sda");
  a_ready_after_done: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(volt_rdy_ff) |-> $past(cs_ff) == CS_DONE) else $error("early ready");
  a_disable_clears: assert property (@(posedge i_clk) disable iff (i_reset)
    !alcfg_ff[ALEN_BIT] |=> !alf_ff) else $error("flag kept");
  a_fault_reasserts: assert property (@(posedge i_clk) disable iff (i_reset)
    fault_s_ff[1] && alcfg_ff[ALEN_BIT] |=> ##1 o_alert_oe) else $error("no reassert");
  a_recover_wait: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_ff == CS_RECOVER && mode == MODE_PDOWN |=> cs_ff != CS_SHUNT && cs_ff != CS_BUS)
    else $error("converted in power down");
  a_shunt_then_bus: assert property (@(posedge i_clk) disable iff (i_reset)
    cs_ff == CS_SHUNT && $past(mode) == MODE_CONT_BOTH && mode == MODE_CONT_BOTH
    |=> cs_ff == CS_SHUNT || cs_ff == CS_BUS) else $error("bad order");
  a_ara_gated: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(as_ff == AS_ACK) |-> alcfg_ff[LATCH_BIT]) else $error("ara unlatched");
endmodule : pmac_core
`default_nettype wire

// File: verif/pmac_smb_host.sv
// Two-wire host model that runs alert response reads
`timescale 1ns/1ps
`default_nettype none
module pmac_smb_host (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  import pmac_pkg::*;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // One bit with SCL low on entry; 48 ns per bit
  task automatic bit_cyc(input logic drv_low, output logic smp);
    #12 o_sda_oe = drv_low;
    #12 o_scl = 1'b1;
    #12 smp = i_sda;
    #12 o_scl = 1'b0;
  endtask : bit_cyc
  // Rival stands for a second alerting device pulling its zero bits
  task automatic ara_read(input logic [7:0] rival, output logic ack, output logic [7:0] data);
    logic s;
    logic [7:0] hdr;
    hdr = {ARA_ADDR, 1'b1};
    o_sda_oe = 1'b1;
    #24 o_scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(!hdr[i], s);
    end
    bit_cyc(1'b0, s);
    ack = !s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(!rival[i], s);
      data[i] = s;
    end
    bit_cyc(1'b0, s);
    #12 o_sda_oe = 1'b1;
    #12 o_scl = 1'b1;
    #24 o_sda_oe = 1'b0;
    #24;
  endtask : ara_read
endmodule : pmac_smb_host
`default_nettype wire

// File: verif/power_monitor_alert_control_tb.sv
// Testbench for the conversion sequencer and alert logic
`timescale 1ns/1ps
`default_nettype none
module power_monitor_alert_control_tb;
  import pmac_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] shunt = 16'h1234;
  logic [15:0] bus = 16'h0ABC;
  logic fault = 1'b0;
  logic scl;
  logic host_oe;
  logic dev_oe;
  logic sda_out;
  logic alert_oe;
  logic alert_out;
  logic busy;
  wire logic sda_w;
  wire logic alert_w;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic ack;
  logic [7:0] got;
  logic [31:0] r;
  logic er;
  assign sda_w = !(host_oe | dev_oe);
  assign alert_w = !alert_oe;
  always #2.5 clk = ~clk;
  pmac_core #(.RECOVER_CYCLES(20), .SAMPLE_CYCLES(4)) uut (
    .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_shunt_sample(shunt), .i_bus_sample(bus), .i_fault(fault),
    .i_scl(scl), .i_sda(sda_w), .o_sda_oe(dev_oe), .o_sda_out(sda_out),
    .o_alert_oe(alert_oe), .o_alert_out(alert_out), .o_conv_busy(busy)
  );
  pmac_smb_host host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda_w));
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("BAD %0t no pready", $time);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, d, q, err);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    logic err;
    apb(1'b0, a, 32'h0, q, err);
    chk(q & m, e);
  endtask : rdc
  task automatic wait_rdy;
    logic [31:0] q;
    logic err;
    int n;
    n = 0;
    do begin
      apb(1'b0, STAT_OFF, 32'h0, q, err);
      n++;
    end while (q[VOLT_RDY_BIT] !== 1'b1 && n < 200);
    chk({31'h0, q[VOLT_RDY_BIT]}, 32'h1);
  endtask : wait_rdy
  task automatic ara(input logic [7:0] rival);
    @(posedge clk);
    #0.5;
    host.ara_read(rival, ack, got);
  endtask : ara
  task automatic pulse_fault;
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    fault <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse_fault
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(CFG_OFF, 32'h0000FFFF, {16'h0, CFG_RST});
    rdc(ALCFG_OFF, 32'h3, {30'h0, ALCFG_RST});
    rdc(ADDR_OFF, 32'h7F, {25'h0, ADDR_RST});
    apb(1'b0, 8'h08, 32'h0, r, er);
    chk({er, r[30:0]}, 32'h80000000);
    chk({31'h0, alert_w}, 32'h1);
    wait_rdy();
    rdc(SHUNT_OFF, 32'h0000FFFF, 32'h00001234);
    rdc(BUS_OFF, 32'h0000FFFF, 32'h00000ABC);
    rdc(CURR_OFF, 32'h0000FFFF, 32'h0);
    wr(CFG_OFF, 32'h00001807);
    rdc(CFG_OFF, 32'h00003FFF, 32'h00001807);
    wr(CFG_OFF, 32'h00002000);
    repeat (40) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    rdc(STAT_OFF, 32'h40, 32'h40);
    wr(CFG_OFF, 32'h00006003);
    rdc(STAT_OFF, 32'h40, 32'h0);
    wait_rdy();
    shunt <= 16'h0777;
    bus <= 16'h0555;
    wr(CFG_OFF, 32'h00006001);
    wait_rdy();
    rdc(SHUNT_OFF, 32'h0000FFFF, 32'h00000777);
    rdc(BUS_OFF, 32'h0000FFFF, 32'h00000ABC);
    repeat (100) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    rdc(STAT_OFF, 32'h40, 32'h0);
    wr(CFG_OFF, {16'h0, CFG_RST});
    wr(ALCFG_OFF, 32'h3);
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    chk({31'h0, alert_w}, 32'h0);
    wait_rdy();
    chk({31'h0, alert_w}, 32'h0);
    fault <= 1'b0;
    repeat (10) @(posedge clk);
    chk({31'h0, alert_w}, 32'h0);
    rdc(STAT_OFF, 32'h1, 32'h1);
    repeat (10) @(posedge clk);
    chk({31'h0, alert_w}, 32'h1);
    pulse_fault();
    ara(8'h39);
    chk({23'h0, ack, got}, 32'h00000139);
    chk({31'h0, alert_w}, 32'h0);
    ara(8'hFF);
    chk({23'h0, ack, got}, {23'h0, 1'b1, ADDR_RST, 1'b1});
    repeat (10) @(posedge clk);
    chk({31'h0, alert_w}, 32'h1);
    wr(ALCFG_OFF, 32'h2);
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    ara(8'hFF);
    chk({31'h0, ack}, 32'h0);
    fault <= 1'b0;
    wr(ALCFG_OFF, 32'h3);
    pulse_fault();
    wr(ALCFG_OFF, 32'h0);
    repeat (10) @(posedge clk);
    chk({31'h0, alert_w}, 32'h1);
    rdc(STAT_OFF, 32'h1, 32'h0);
    chk({30'h0, alert_out, sda_out}, 32'h0);
    stop_test();
  end
endmodule : power_monitor_alert_control_tb
`default_nettype wire
